/* File: verilog/snc_station_config.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Tens from middle switch, ones from bottom
// - Valid 1..63 reduced, 1..62 monitor
// - Out of range: flag error, indicator on
// - Sample switches once at power-up, hold
// - Later switch moves change nothing active
// - Live switches differing from capture: error
// - Duplicate station reported: error, stop communicating
// - Rate switch 0-4 reduced, 5-9 monitor
// - Change during communication: indicator flashes
module snc_station_config #(
  parameter int FLASH_HALF = snc_pkg::SNC_FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Switch pins
  input  wire logic [3:0]  station_tens_sw,
  input  wire logic [3:0]  station_ones_sw,
  input  wire logic [3:0]  rate_mode_switch,
  // Network status
  input  wire logic        link_active,
  input  wire logic        dup_station,
  input  wire logic        comm_error,
  // Captured settings
  output logic      [6:0]  station_number,
  output logic      [2:0]  rate_sel,
  output logic             monitor_mode,
  output logic             comm_enable,
  // Indicator and interrupt
  output logic             err_led,
  output logic             irq
);

  typedef enum {
    SNC_SETTLE,
    SNC_CAPTURE,
    SNC_RUN
  } snc_state_t;

  snc_state_t            state;
  snc_state_t            next_state;
  logic [2:0]            settle_cnt;
  snc_pkg::snc_setting_t live;
  snc_pkg::snc_setting_t held;
  logic                  link_s;
  logic                  dup_s;
  logic                  cerr_s;
  logic                  range_err;
  logic                  change_err;
  logic                  change_flash;
  logic                  dup_err;
  logic [snc_pkg::SNC_EV_W-1:0] ev_status;
  logic [snc_pkg::SNC_EV_W-1:0] ev_mask;
  logic                  wr_pend;
  logic                  rd_pend;
  logic [7:0]            dp_addr;
  logic                  blink;

  // Pins are asynchronous to hclk
  snc_sync #(.W(12)) u_sw_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_async ({station_tens_sw, station_ones_sw, rate_mode_switch}),
    .q_sync  (live)
  );

  snc_sync #(.W(3)) u_net_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_async ({link_active, dup_station, comm_error}),
    .q_sync  ({link_s, dup_s, cerr_s})
  );

  snc_blink #(.HALF(FLASH_HALF)) u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .blink   (blink)
  );

  // Decode of the held settings
  wire       captured   = (state == SNC_RUN);
  wire [6:0] held_tens  = 7'(held.tens) * 7'(snc_pkg::SNC_TENS_WEIGHT);
  wire [6:0] held_stn   = held_tens + 7'(held.ones);
  wire       held_mon   = (held.rate >= snc_pkg::SNC_MODE_SPLIT);
  wire [3:0] held_rix   = held_mon ? held.rate - snc_pkg::SNC_MODE_SPLIT : held.rate;
  wire [6:0] stn_max    = held_mon ? snc_pkg::SNC_STN_MAX_MON : snc_pkg::SNC_STN_MAX_RED;
  wire       digit_bad  = (held.tens > snc_pkg::SNC_DIGIT_MAX) ||
                          (held.ones > snc_pkg::SNC_DIGIT_MAX) ||
                          (held.rate > snc_pkg::SNC_DIGIT_MAX);
  wire       range_bad  = digit_bad || (held_stn < snc_pkg::SNC_STN_MIN) ||
                          (held_stn > stn_max);
  // Each switch compared on its own so any one of them counts
  wire       tens_moved = (live.tens != held.tens);
  wire       ones_moved = (live.ones != held.ones);
  wire       rate_moved = (live.rate != held.rate);
  wire       sw_moved   = captured && (tens_moved || ones_moved || rate_moved);

  // Start-up sequence: wait for the synchronisers to fill, then sample once
  always_comb begin
    next_state = state;
    case (state)
      SNC_SETTLE: begin
        if (settle_cnt == 3'(snc_pkg::SNC_SETTLE_CYCLES - 1)) begin
          next_state = SNC_CAPTURE;
        end
      end
      SNC_CAPTURE: begin
        next_state = SNC_RUN;
      end
      default: begin
        next_state = SNC_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= SNC_SETTLE;
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      // Counter parks after start-up so it never wraps back into range
      if (state == SNC_SETTLE) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  // Settings taken once; only a new reset reopens the capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= '0;
    end else if (state == SNC_CAPTURE) begin
      held <= live;
    end
  end

  // Outputs follow only the held copy, never the live pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      station_number <= 7'h0;
      rate_sel       <= 3'h0;
      monitor_mode   <= 1'b0;
    end else if (captured) begin
      station_number <= held_stn;
      rate_sel       <= held_rix[2:0];
      monitor_mode   <= held_mon;
    end
  end

  // Range error follows the held copy, which cannot change before reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_err <= 1'b0;
    end else begin
      range_err <= captured && range_bad;
    end
  end

  // Change and duplicate flags are sticky until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_err   <= 1'b0;
      change_flash <= 1'b0;
      dup_err      <= 1'b0;
    end else begin
      if (sw_moved) begin
        change_err <= 1'b1;
      end
      if (sw_moved && link_s) begin
        change_flash <= 1'b1;
      end
      if (captured && dup_s) begin
        dup_err <= 1'b1;
      end
    end
  end

  // Flashing beats steady so a mid-run switch move stays recognisable
  wire steady_err = range_err || change_err || dup_err || cerr_s;
  wire next_led   = change_flash ? blink : steady_err;
  // Live duplicate report drops the link in the same cycle that the sticky flag is set
  wire next_comm  = captured && !range_bad && !dup_err && !dup_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_led     <= 1'b0;
      comm_enable <= 1'b0;
    end else begin
      err_led     <= next_led;
      comm_enable <= next_comm;
    end
  end

  // Bus address phase and decode
  wire        ap_valid  = hsel && hready && htrans[1];
  wire        ap_write  = ap_valid && hwrite;
  wire        ap_read   = ap_valid && !hwrite;
  wire        sel_status = (dp_addr == snc_pkg::SNC_REG_STATUS);
  wire        sel_event  = (dp_addr == snc_pkg::SNC_REG_EVENT);
  wire        sel_mask   = (dp_addr == snc_pkg::SNC_REG_MASK);
  wire        sel_live   = (dp_addr == snc_pkg::SNC_REG_LIVE);
  wire        wr_event   = wr_pend && sel_event;
  wire        wr_mask    = wr_pend && sel_mask;

  logic [snc_pkg::SNC_EV_W-1:0] ev_set;
  wire  [snc_pkg::SNC_EV_W-1:0] next_ev;
  wire  [snc_pkg::SNC_EV_W-1:0] ev_clr = wr_event ? hwdata[snc_pkg::SNC_EV_W-1:0] : '0;

  always_comb begin
    ev_set                         = '0;
    ev_set[snc_pkg::SNC_EV_RANGE]  = range_err;
    ev_set[snc_pkg::SNC_EV_CHANGE] = change_err;
    ev_set[snc_pkg::SNC_EV_DUP]    = dup_err;
  end

  // Set wins over a simultaneous write-one clear
  genvar b;
  generate
    for (b = 0; b < snc_pkg::SNC_EV_W; b++) begin : g_ev
      assign next_ev[b] = ev_set[b] || (ev_status[b] && !ev_clr[b]);
    end
  endgenerate

  logic [31:0] st_word;
  always_comb begin
    st_word                               = 32'h0;
    st_word[snc_pkg::SNC_ST_STATION +: 7] = station_number;
    st_word[snc_pkg::SNC_ST_RATE +: 3]    = rate_sel;
    st_word[snc_pkg::SNC_ST_MONITOR]      = monitor_mode;
    st_word[snc_pkg::SNC_ST_CAPT]         = captured;
    st_word[snc_pkg::SNC_ST_COMM]         = comm_enable;
    st_word[snc_pkg::SNC_ST_FLASH]        = change_flash;
    st_word[snc_pkg::SNC_ST_ERR]          = err_led;
  end

  // Address decoding, first match wins
  logic [31:0] rd_word;
  always_comb begin
    if (sel_status) begin
      rd_word = st_word;
    end else if (sel_event) begin
      rd_word = {29'h0, ev_status};
    end else if (sel_mask) begin
      rd_word = {29'h0, ev_mask};
    end else if (sel_live) begin
      rd_word = {20'h0, live};
    end else begin
      rd_word = 32'h0;
    end
  end

  // Address phase held for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h0;
    end else begin
      wr_pend <= ap_write;
      rd_pend <= ap_read;
      if (ap_valid) begin
        dp_addr <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Reads take one wait state so the data leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !ap_read;
      hresp     <= 1'b0;
      if (rd_pend) begin
        hrdata <= rd_word;
      end
    end
  end

  // Event status, mask and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_status <= '0;
      ev_mask   <= snc_pkg::SNC_MASK_RST;
      irq       <= 1'b0;
    end else begin
      ev_status <= next_ev;
      if (wr_mask) begin
        ev_mask <= hwdata[snc_pkg::SNC_EV_W-1:0];
      end
      irq <= |(next_ev & ev_mask);
    end
  end

endmodule : snc_station_config

/* File: verilog/snc_pkg.sv */
package snc_pkg;

  // Rotary switch digits, BCD
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] ones;
    logic [3:0] rate;
  } snc_setting_t;

  typedef enum logic [2:0] {
    SNC_RATE_156K,
    SNC_RATE_625K,
    SNC_RATE_2M5,
    SNC_RATE_5M,
    SNC_RATE_10M
  } snc_rate_t;

  // Register byte offsets
  localparam logic [7:0] SNC_REG_STATUS  = 8'h00;
  localparam logic [7:0] SNC_REG_EVENT   = 8'h04;
  localparam logic [7:0] SNC_REG_MASK    = 8'h08;
  localparam logic [7:0] SNC_REG_LIVE    = 8'h0c;

  // Event bit positions (event and mask registers)
  localparam int SNC_EV_RANGE  = 0;
  localparam int SNC_EV_CHANGE = 1;
  localparam int SNC_EV_DUP    = 2;
  localparam int SNC_EV_W      = 3;

  // Status register field positions
  localparam int SNC_ST_STATION = 0;
  localparam int SNC_ST_RATE    = 8;
  localparam int SNC_ST_MONITOR = 11;
  localparam int SNC_ST_CAPT    = 12;
  localparam int SNC_ST_COMM    = 13;
  localparam int SNC_ST_FLASH   = 14;
  localparam int SNC_ST_ERR     = 15;

  // Reset values
  localparam logic [SNC_EV_W-1:0] SNC_MASK_RST = 3'h0;

  // Station limits per mode
  localparam logic [6:0] SNC_STN_MIN     = 7'h01;
  localparam logic [6:0] SNC_STN_MAX_RED = 7'h3f;
  localparam logic [6:0] SNC_STN_MAX_MON = 7'h3e;
  localparam logic [3:0] SNC_DIGIT_MAX   = 4'h9;
  localparam logic [3:0] SNC_MODE_SPLIT  = 4'h5;
  localparam logic [3:0] SNC_TENS_WEIGHT = 4'ha;

  // Timing
  localparam int  SNC_CLK_MHZ        = 100;
  localparam int  SNC_SETTLE_CYCLES  = 4;
  localparam int  SNC_FLASH_HALF_MS  = 250;
  localparam int  SNC_FLASH_HALF_CYC = SNC_FLASH_HALF_MS * 1000 * SNC_CLK_MHZ;

endpackage : snc_pkg

/* File: verilog/snc_sync.sv */
`timescale 1ns/1ps
module snc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta;

  // One two-stage chain per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i]   <= 1'b0;
          q_sync[i] <= 1'b0;
        end else begin
          meta[i]   <= d_async[i];
          q_sync[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : snc_sync

/* File: verilog/snc_blink.sv */
`timescale 1ns/1ps
module snc_blink #(
  parameter int HALF = 25000000
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Blink level
  output logic      blink
);

  logic [31:0] cnt;
  wire         tick = (cnt == 32'(HALF - 1));

  // Divider: one-cycle enable flips the level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt   <= 32'h0;
      blink <= 1'b0;
    end else begin
      cnt <= tick ? 32'h0 : cnt + 32'h1;
      if (tick) begin
        blink <= ~blink;
      end
    end
  end

endmodule : snc_blink

/* File: tb/snc_station_config_properties.sv */
`timescale 1ns/1ps
module snc_station_config_properties (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus
  input wire logic       hsel,
  input wire logic       hready,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Switch pins and network
  input wire logic [3:0] station_tens_sw,
  input wire logic [3:0] station_ones_sw,
  input wire logic [3:0] rate_mode_switch,
  input wire logic       dup_station,
  // Captured settings
  input wire logic [6:0] station_number,
  input wire logic [2:0] rate_sel,
  input wire logic       monitor_mode,
  input wire logic       comm_enable
);
  logic [3:0] cnt;
  logic [3:0] cap_t;
  logic [3:0] cap_o;
  logic [3:0] cap_r;
  logic       run;
  assign run = (cnt == 4'hf);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 4'h0;
    else if (!run) cnt <= cnt + 4'h1;
  end
  // Pins are held still through boot, so one early sample is enough
  always_ff @(posedge hclk) begin
    if (cnt == 4'h1) cap_t <= station_tens_sw;
    if (cnt == 4'h1) cap_o <= station_ones_sw;
    if (cnt == 4'h1) cap_r <= rate_mode_switch;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence s_wr; hsel && hready && htrans[1] && hwrite; endsequence
  sequence s_off; !comm_enable [*3]; endsequence
  property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr_fast; s_wr |=> hreadyout && !hresp; endproperty
  property p_okay; s_rd |=> !hresp [*2]; endproperty
  property p_stn;
    run |-> station_number == 7'(cap_t) * 7'h0a + 7'(cap_o);
  endproperty
  property p_mode;
    run |-> monitor_mode == (cap_r >= 4'h5)
      && rate_sel == 3'(cap_r >= 4'h5 ? cap_r - 4'h5 : cap_r);
  endproperty
  property p_hold;
    run |-> $stable(station_number) && $stable(rate_sel) && $stable(monitor_mode);
  endproperty
  property p_range;
    run && (station_number == 7'h00
      || station_number > (monitor_mode ? 7'h3e : 7'h3f)) |-> !comm_enable;
  endproperty
  property p_dup; $rose(dup_station) |-> ##[1:4] s_off; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_stn: assert property (p_stn) else $error("station number wrong");
  a_mode: assert property (p_mode) else $error("rate or mode wrong");
  a_hold: assert property (p_hold) else $error("captured value moved");
  a_range: assert property (p_range) else $error("out of range enabled");
  a_dup: assert property (p_dup) else $error("duplicate kept running");
endmodule : snc_station_config_properties

bind snc_station_config snc_station_config_properties i_props (
  .hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout, .hresp,
  .station_tens_sw, .station_ones_sw, .rate_mode_switch, .dup_station,
  .station_number, .rate_sel, .monitor_mode, .comm_enable
);

/* File: tb/snc_net_model.sv */
`timescale 1ns/1ps
module snc_net_model #(
  parameter int LAG = 3
) (
  // Clock and commands
  input  wire logic       hclk,
  input  wire logic       slow,
  input  wire logic [2:0] want,
  // Network status
  output logic            link_active,
  output logic            dup_station,
  output logic            comm_error
);
  logic [LAG-1:0][2:0] pipe = '0;
  // Slow answers stand for a master that needs several scans
  always @(posedge hclk) pipe <= {pipe[LAG-2:0], want};
  assign {link_active, dup_station, comm_error} = slow ? pipe[LAG-1] : pipe[0];
endmodule : snc_net_model

/* File: tb/tb_station_number_config.sv */
`timescale 1ns/1ps
module tb_station_number_config;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, hrdata;
  logic [3:0]  st_t = 0, st_o = 0, st_r = 0, t, o;
  logic [2:0]  want = 0, rate_sel;
  logic [6:0]  station_number, s;
  logic        hreadyout, hresp, link, dup, cerr, mon, comm_enable, err_led, irq;
  logic        ok, led0, rd_pend = 0;
  logic [31:0] expq[$];
  int          num_errors = 0, checks_done = 0, seed = 63343, cyc = 0;
  always #5 hclk = ~hclk;
  snc_station_config #(.FLASH_HALF(8)) i_snc_station_config (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .station_tens_sw(st_t), .station_ones_sw(st_o), .rate_mode_switch(st_r),
    .link_active(link), .dup_station(dup), .comm_error(cerr), .station_number,
    .rate_sel, .monitor_mode(mon), .comm_enable, .err_led, .irq);
  snc_net_model i_snc_net_model (.hclk, .slow, .want, .link_active(link),
    .dup_station(dup), .comm_error(cerr));
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge hclk); while (!hreadyout);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (!hreadyout);
  endtask : bus
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic boot(logic [3:0] bt, logic [3:0] bo, logic [3:0] br);
    @(posedge hclk);
    {hresetn, st_t, st_o, st_r, want} <= {1'b0, bt, bo, br, 3'h0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask : boot
  always @(posedge hclk) begin
    if (rd_pend && hreadyout) chk("hrdata", expq.pop_front(), hrdata);
    if (rd_pend && hreadyout) rd_pend <= 1'b0;
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_pend <= 1'b1;
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    for (int i = 0; i < 10; i++) begin
      t = 4'($unsigned($random(seed)) % 7);
      o = 4'($unsigned($random(seed)) % 10);
      if (i == 4 || i == 9) {t, o} = 8'h63;
      if (i == 0) {t, o} = 8'h00;
      boot(t, o, 4'(i));
      s = 7'(t * 10 + o);
      ok = s != 0 && s <= (i >= 5 ? 62 : 63);
      rd(snc_pkg::SNC_REG_STATUS, {16'h0, !ok, 1'b0, ok, 1'b1, i >= 5, 3'(i % 5), 1'b0, s});
      rd(snc_pkg::SNC_REG_EVENT, {31'h0, !ok});
      bus(1'b1, snc_pkg::SNC_REG_MASK, 32'h1);
      repeat (3) @(negedge hclk);
      chk("irq", !ok, irq);
      chk("comm_enable", ok, comm_enable);
    end
    // Switch moved during link, then put back
    boot(4'h2, 4'h1, 4'h2);
    want <= 3'h4;
    bus(1'b1, snc_pkg::SNC_REG_MASK, 32'h2);
    st_o <= 4'h7;
    repeat (8) @(posedge hclk);
    st_o <= 4'h1;
    @(negedge hclk) led0 = err_led;
    repeat (8) @(negedge hclk);
    chk("err_led", !led0, err_led);
    chk("irq", 1, irq);
    chk("station_number", 21, station_number);
    bus(1'b1, snc_pkg::SNC_REG_EVENT, 32'h7);
    rd(snc_pkg::SNC_REG_EVENT, 32'h2);
    rd(snc_pkg::SNC_REG_LIVE, 32'h212);
    rd(8'h40, 32'h0);
    bus(1'b1, snc_pkg::SNC_REG_MASK, 32'h0);
    repeat (3) @(negedge hclk);
    chk("irq", 0, irq);
    // Duplicate station reported by a slow master
    boot(4'h2, 4'h1, 4'h2);
    {slow, want} <= 4'he;
    repeat (12) @(negedge hclk);
    chk("comm_enable", 0, comm_enable);
    chk("err_led", 1, err_led);
    rd(snc_pkg::SNC_REG_EVENT, 32'h4);
    // Transient fault lights the indicator only while present
    boot(4'h2, 4'h1, 4'h2);
    want <= 3'h5;
    repeat (12) @(negedge hclk);
    chk("err_led", 1, err_led);
    want <= 3'h4;
    repeat (12) @(negedge hclk);
    chk("err_led", 0, err_led);
    chk("comm_enable", 1, comm_enable);
    tally_and_finish();
  end
endmodule : tb_station_number_config
